// *** core/pmst_pkg.sv ***
// Purpose: constants for the phy mac-side tuning register bank
// Assumes: one 125 MHz clock, 16-bit registers on a plain port
// Notes:
package pmst_pkg;
  localparam logic [7:0]  OFS_LATENCY_CTRL = 8'h33;
  localparam logic [7:0]  OFS_NEG_STATUS   = 8'h37;
  localparam logic [7:0]  OFS_CHK_CTRL     = 8'h39;
  localparam logic [7:0]  OFS_CHK_TOTAL    = 8'h3a;
  localparam logic [7:0]  OFS_FAST_TUNE    = 8'h43;
  localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h3c;
  localparam logic [7:0]  OFS_IRQ_MASK     = 8'h3d;
  localparam logic [15:0] RST_LATENCY_CTRL = 16'h0000;
  localparam logic [15:0] RST_CHK_CTRL     = 16'h0000;
  localparam logic [15:0] RST_FAST_TUNE    = 16'h07a0;
  localparam logic [15:0] FAST_TUNE_RW     = 16'h0fff;
  localparam int          BIT_SKIP         = 4;
  localparam int          BIT_SKIP_DLY     = 3;
  localparam int          BIT_LOW_LAT      = 2;
  localparam int          BIT_RX_THR_TOP   = 1;
  localparam int          BIT_TX_THR_TOP   = 0;
  localparam int          BIT_PAGE_RX      = 1;
  localparam int          BIT_NEG_DONE     = 0;
  localparam int          BIT_LOCK         = 7;
  localparam int          BIT_LOCK_CLR     = 8;
  localparam int          BIT_SYNC_LOST    = 5;
  localparam int          BIT_LOCKED       = 4;
  localparam int          BIT_OVF          = 2;
  localparam int          BIT_CONT         = 1;
  localparam int          BIT_EN           = 0;
  localparam int          BIT_EARLY_RV     = 0;
  localparam logic [7:0]  ERR_MAX          = 8'hff;
  localparam logic [15:0] TOTAL_MAX        = 16'hffff;
  localparam int          FIFO_DEPTH       = 8;
  localparam logic [2:0]  THR_TO_DIFF_ADD  = 3'h2;
  localparam int          IRQ_W            = 4;
  localparam logic [3:0]  IRQ_RST          = 4'h0;
endpackage

// *** core/pmst_regs.sv ***
// Purpose: phy mac-side tuning and prbs checker register bank
// Assumes: checker byte/error/lock/sync inputs are in clk_i domain
// Notes: interrupt status bits: 0 page rx, 1 neg done, 2 sync lost, 3 ovf
`timescale 1ns/1ns
module pmst_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        page_rx_i,
  input  wire logic        neg_done_i,
  input  wire logic        chk_byte_i,
  input  wire logic        chk_err_i,
  input  wire logic        chk_locked_i,
  input  wire logic        chk_sync_lost_i,
  output logic             async_fifo_skip_enable_o,
  output logic             async_fifo_skip_clock_delay_o,
  output logic             low_latency_o,
  output logic      [2:0]  rx_fifo_threshold_o,
  output logic      [2:0]  tx_fifo_threshold_o,
  output logic      [3:0]  rx_fifo_start_diff_o,
  output logic      [3:0]  tx_fifo_start_diff_o,
  output logic             checker_enable_o,
  output logic             checker_count_continuous_o,
  output logic             early_receive_valid_o,
  output logic             irq_o
);
  localparam int IRQ_W = pmst_pkg::IRQ_W;
  logic [15:0] lat_reg;
  logic [15:0] fast_reg;
  logic [1:0]  chk_mode_reg;
  logic [1:0]  rx_thr_low_reg;
  logic [1:0]  tx_thr_low_reg;
  logic        page_rx_reg;
  logic        sync_lost_reg;
  logic        ovf_reg;
  logic [7:0]  err_cnt_reg;
  logic [15:0] tot_cnt_reg;
  logic [7:0]  err_snap_reg;
  logic [15:0] tot_snap_reg;
  logic [IRQ_W-1:0] irq_sts_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic        neg_done_d_reg;
  logic        wr_ctrl;
  logic        lock_p;
  logic        clr_p;
  logic        cont;
  logic [15:0] rdata_next;
  logic [IRQ_W-1:0] irq_ev;

  function automatic logic [3:0] start_diff(input logic [2:0] thr);
    start_diff = {1'b0, thr} + {1'b0, pmst_pkg::THR_TO_DIFF_ADD};
  endfunction

  assign wr_ctrl = wr_i && (addr_i == pmst_pkg::OFS_CHK_CTRL);
  assign lock_p  = wr_ctrl && wdata_i[pmst_pkg::BIT_LOCK];
  assign clr_p   = wr_ctrl && wdata_i[pmst_pkg::BIT_LOCK_CLR];
  assign cont    = chk_mode_reg[pmst_pkg::BIT_CONT];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lat_reg <= pmst_pkg::RST_LATENCY_CTRL;
    end else if (wr_i && addr_i == pmst_pkg::OFS_LATENCY_CTRL) begin
      lat_reg <= {11'h000, wdata_i[4:0]};
    end
  end

  // low threshold bits reset to 2 and hold; no register address writes them
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_thr_low_reg <= 2'h2;
      tx_thr_low_reg <= 2'h2;
    end else begin
      rx_thr_low_reg <= rx_thr_low_reg;
      tx_thr_low_reg <= tx_thr_low_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fast_reg <= pmst_pkg::RST_FAST_TUNE;
    end else if (wr_i && addr_i == pmst_pkg::OFS_FAST_TUNE) begin
      fast_reg <= wdata_i & pmst_pkg::FAST_TUNE_RW;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chk_mode_reg <= 2'h0;
    end else if (wr_ctrl) begin
      chk_mode_reg <= wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_cnt_reg <= 8'h00;
    end else if (clr_p) begin
      err_cnt_reg <= 8'h00;
    end else if (checker_enable_o && chk_byte_i && chk_err_i &&
                 (cont || err_cnt_reg != pmst_pkg::ERR_MAX)) begin
      err_cnt_reg <= err_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tot_cnt_reg <= 16'h0000;
    end else if (clr_p) begin
      tot_cnt_reg <= 16'h0000;
    end else if (checker_enable_o && chk_byte_i &&
                 (cont || tot_cnt_reg != pmst_pkg::TOTAL_MAX)) begin
      tot_cnt_reg <= tot_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_snap_reg <= 8'h00;
      tot_snap_reg <= 16'h0000;
    end else if (lock_p || clr_p) begin
      err_snap_reg <= err_cnt_reg;
      tot_snap_reg <= tot_cnt_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovf_reg <= 1'b0;
    end else if (checker_enable_o && chk_byte_i &&
                 tot_cnt_reg == pmst_pkg::TOTAL_MAX) begin
      ovf_reg <= 1'b1;
    end else if (clr_p) begin
      ovf_reg <= 1'b0;
    end
  end

  // latched high, read clears; set wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_lost_reg <= 1'b0;
    end else if (chk_sync_lost_i && checker_enable_o) begin
      sync_lost_reg <= 1'b1;
    end else if (rd_i && addr_i == pmst_pkg::OFS_CHK_CTRL) begin
      sync_lost_reg <= 1'b0;
    end
  end

  // page received, read clears; set wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      page_rx_reg <= 1'b0;
    end else if (page_rx_i) begin
      page_rx_reg <= 1'b1;
    end else if (rd_i && addr_i == pmst_pkg::OFS_NEG_STATUS) begin
      page_rx_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      neg_done_d_reg <= 1'b0;
    end else begin
      neg_done_d_reg <= neg_done_i;
    end
  end

  assign irq_ev = {ovf_reg == 1'b0 && checker_enable_o && chk_byte_i &&
                   tot_cnt_reg == pmst_pkg::TOTAL_MAX,
                   chk_sync_lost_i && checker_enable_o,
                   neg_done_i && !neg_done_d_reg,
                   page_rx_i};

  // sticky events, write one clears, event wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_sts_reg <= pmst_pkg::IRQ_RST;
    end else if (wr_i && addr_i == pmst_pkg::OFS_IRQ_STATUS) begin
      irq_sts_reg <= (irq_sts_reg & ~wdata_i[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_sts_reg <= irq_sts_reg | irq_ev;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask_reg <= pmst_pkg::IRQ_RST;
    end else if (wr_i && addr_i == pmst_pkg::OFS_IRQ_MASK) begin
      irq_mask_reg <= wdata_i[IRQ_W-1:0];
    end
  end

  always_comb begin
    rdata_next = 16'h0000;
    case (addr_i)
      pmst_pkg::OFS_LATENCY_CTRL: rdata_next = lat_reg;
      pmst_pkg::OFS_NEG_STATUS:
        rdata_next = {14'h0000, page_rx_reg, neg_done_i};
      pmst_pkg::OFS_CHK_CTRL:
        rdata_next = {1'b0, err_snap_reg, 1'b0, sync_lost_reg,
                      chk_locked_i, 1'b0, ovf_reg, chk_mode_reg};
      pmst_pkg::OFS_CHK_TOTAL:  rdata_next = tot_snap_reg;
      pmst_pkg::OFS_FAST_TUNE:  rdata_next = fast_reg;
      pmst_pkg::OFS_IRQ_STATUS: rdata_next = {12'h000, irq_sts_reg};
      pmst_pkg::OFS_IRQ_MASK:   rdata_next = {12'h000, irq_mask_reg};
      default:                  rdata_next = 16'h0000;
    endcase
  end

  // unmapped or write cycles read zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  assign async_fifo_skip_enable_o      = lat_reg[pmst_pkg::BIT_SKIP];
  assign async_fifo_skip_clock_delay_o = lat_reg[pmst_pkg::BIT_SKIP_DLY];
  assign low_latency_o                 = lat_reg[pmst_pkg::BIT_LOW_LAT];
  assign rx_fifo_threshold_o = {lat_reg[pmst_pkg::BIT_RX_THR_TOP],
                                rx_thr_low_reg};
  assign tx_fifo_threshold_o = {lat_reg[pmst_pkg::BIT_TX_THR_TOP],
                                tx_thr_low_reg};
  assign rx_fifo_start_diff_o = start_diff(rx_fifo_threshold_o);
  assign tx_fifo_start_diff_o = start_diff(tx_fifo_threshold_o);
  assign checker_enable_o           = chk_mode_reg[pmst_pkg::BIT_EN];
  assign checker_count_continuous_o = cont;
  assign early_receive_valid_o      = fast_reg[pmst_pkg::BIT_EARLY_RV];
  assign irq_o = |(irq_sts_reg & irq_mask_reg);
endmodule // pmst_regs

// *** verification/pmst_link_model.sv ***
// Purpose: far-side byte source feeding the checker inputs
// Assumes: one byte per clock while a burst runs
// Notes: error output toggles while no byte is qualified so no stale value shows
`timescale 1ns/1ns
module pmst_link_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        go_i,
  input  wire logic [16:0] num_i,
  input  wire logic        err_i,
  output logic             byte_o,
  output logic             err_o
);
  logic [16:0] left_reg;
  logic        tog_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      left_reg <= 17'h00000;
      tog_reg  <= 1'b0;
    end else begin
      tog_reg <= ~tog_reg;
      if (go_i) begin
        left_reg <= num_i;
      end else if (byte_o) begin
        left_reg <= left_reg - 17'h00001;
      end
    end
  end
  assign byte_o = (left_reg != 17'h00000);
  assign err_o  = byte_o ? err_i : tog_reg;
endmodule // pmst_link_model

// *** verification/pmst_regs_monitor.sv ***
// Purpose: port checks for the tuning register bank
// Assumes: one clock, async active-low reset
// Notes: controls follow a write by one cycle
`timescale 1ns/1ns
module pmst_regs_monitor (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        async_fifo_skip_enable_o,
  input wire logic        async_fifo_skip_clock_delay_o,
  input wire logic        low_latency_o,
  input wire logic [2:0]  rx_fifo_threshold_o,
  input wire logic [2:0]  tx_fifo_threshold_o,
  input wire logic [3:0]  rx_fifo_start_diff_o,
  input wire logic        checker_enable_o,
  input wire logic        early_receive_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire w33 = wr_i && addr_i == 8'h33;
  wire w39 = wr_i && addr_i == 8'h39;
  wire w43 = wr_i && addr_i == 8'h43;
  a_skip_enable: assert property (w33 |=>
    async_fifo_skip_enable_o == $past(wdata_i[4])) else $error("skip");
  a_skip_delay: assert property (w33 |=>
    async_fifo_skip_clock_delay_o == $past(wdata_i[3])) else $error("dly");
  a_low_latency: assert property (w33 |=>
    low_latency_o == $past(wdata_i[2])) else $error("low latency");
  a_rx_threshold: assert property (w33 |=>
    rx_fifo_threshold_o == {$past(wdata_i[1]), 2'b10}) else $error("rx thr");
  a_tx_threshold: assert property (w33 |=>
    tx_fifo_threshold_o == {$past(wdata_i[0]), 2'b10}) else $error("tx thr");
  a_start_diff: assert property (
    rx_fifo_start_diff_o == {1'b0, rx_fifo_threshold_o} + 4'h2)
    else $error("start diff");
  a_chk_enable: assert property (w39 |=>
    checker_enable_o == $past(wdata_i[0])) else $error("chk enable");
  a_early_valid: assert property (w43 |=>
    early_receive_valid_o == $past(wdata_i[0])) else $error("early rv");
  a_unmapped_zero: assert property (rd_i && addr_i == 8'h50 |=>
    rdata_o == 16'h0000) else $error("unmapped read");
  cover property (w39 && wdata_i[8]);
  cover property (rd_i && addr_i == 8'h3a);
  cover property (w43 && wdata_i[0]);
endmodule // pmst_regs_monitor
bind pmst_regs pmst_regs_monitor i_mon (.clk_i, .rst_b_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .async_fifo_skip_enable_o,
  .async_fifo_skip_clock_delay_o, .low_latency_o, .rx_fifo_threshold_o,
  .tx_fifo_threshold_o, .rx_fifo_start_diff_o, .checker_enable_o,
  .early_receive_valid_o);

// *** verification/tb.sv ***
// Purpose: register-level bench for the tuning register bank
// Assumes: bench drives at the rising edge
// Notes: overflow burst is long, about 66k cycles
`timescale 1ns/1ns
module tb;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        page_rx_i = 1'b0;
  logic        neg_done_i = 1'b0;
  logic        chk_locked_i = 1'b0;
  logic        chk_sync_lost_i = 1'b0;
  logic        go = 1'b0;
  logic        err = 1'b0;
  logic [16:0] num = 17'h00000;
  logic        chk_byte_i, chk_err_i, skip, dly, low, en, cont, early, irq;
  logic [2:0]  rxt, txt;
  logic [3:0]  rxd, txd;
  logic [15:0] rdata;
  logic [7:0]  ofs [5] = '{8'h33, 8'h37, 8'h39, 8'h3a, 8'h43};
  logic [15:0] rst_v [5] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h07a0};
  int          mismatches = 0;
  int          check_count = 0;
  pmst_link_model i_link (.clk_i, .rst_b_i, .go_i(go), .num_i(num),
    .err_i(err), .byte_o(chk_byte_i), .err_o(chk_err_i));
  pmst_regs i_dut (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o(rdata), .page_rx_i, .neg_done_i, .chk_byte_i, .chk_err_i,
    .chk_locked_i, .chk_sync_lost_i, .async_fifo_skip_enable_o(skip),
    .async_fifo_skip_clock_delay_o(dly), .low_latency_o(low),
    .rx_fifo_threshold_o(rxt), .tx_fifo_threshold_o(txt),
    .rx_fifo_start_diff_o(rxd), .tx_fifo_start_diff_o(txd),
    .checker_enable_o(en), .checker_count_continuous_o(cont),
    .early_receive_valid_o(early), .irq_o(irq));
  initial forever #4 clk_i = ~clk_i;
  task automatic cmp(input string what, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic pulse(input bit page);
    @(posedge clk_i);
    if (page) page_rx_i <= 1'b1;
    else chk_sync_lost_i <= 1'b1;
    @(posedge clk_i);
    page_rx_i <= 1'b0;
    chk_sync_lost_i <= 1'b0;
  endtask
  // waits bounded; a burst never exceeds 70000 bytes
  task automatic send(input logic [16:0] n, input logic e);
    int k;
    @(posedge clk_i);
    num <= n;
    err <= e;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    #1;
    k = 0;
    while (chk_byte_i === 1'b1 && k < 70000) begin
      @(posedge clk_i);
      #1;
      k++;
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_i);
    mismatches++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], rst_v[i]);
    cmp("diff", 16'h2244, {1'b0, rxt, 1'b0, txt, rxd, txd});
    wr(8'h33, 16'hffff);
    cmp("ctl", 16'h0007, {13'h0, skip, dly, low});
    cmp("thr", 16'h6688, {1'b0, rxt, 1'b0, txt, rxd, txd});
    rd(8'h33, 16'h001f);
    wr(8'h33, 16'h0001);
    cmp("ctl", 16'h0000, {13'h0, skip, dly, low});
    cmp("thr", 16'h2648, {1'b0, rxt, 1'b0, txt, rxd, txd});
    wr(8'h43, 16'hffff);
    cmp("early", 16'h0001, {15'h0, early});
    rd(8'h43, 16'h0fff);
    wr(8'h43, 16'h07a0);
    cmp("early", 16'h0000, {15'h0, early});
    @(posedge clk_i);
    neg_done_i <= 1'b1;
    pulse(1'b1);
    rd(8'h37, 16'h0003);
    rd(8'h37, 16'h0001);
    rd(8'h3c, 16'h0003);
    cmp("irq", 16'h0000, {15'h0, irq});
    wr(8'h3d, 16'h000f);
    cmp("irq", 16'h0001, {15'h0, irq});
    wr(8'h3c, 16'h0003);
    cmp("irq", 16'h0000, {15'h0, irq});
    wr(8'h39, 16'h0001);
    @(posedge clk_i);
    chk_locked_i <= 1'b1;
    send(17'd5, 1'b0);
    send(17'd2, 1'b1);
    wr(8'h39, 16'h0081);
    rd(8'h39, 16'h0111);
    rd(8'h3a, 16'h0007);
    wr(8'h39, 16'h0101);
    rd(8'h3a, 16'h0007);
    wr(8'h39, 16'h0081);
    rd(8'h3a, 16'h0000);
    pulse(1'b0);
    rd(8'h39, 16'h0031);
    rd(8'h39, 16'h0011);
    send(17'd300, 1'b1);
    send(17'd65536, 1'b0);
    wr(8'h39, 16'h0081);
    rd(8'h39, 16'h7f95);
    rd(8'h3a, 16'hffff);
    wr(8'h39, 16'h0103);
    cmp("mode", 16'h0003, {14'h0, cont, en});
    send(17'd257, 1'b1);
    wr(8'h39, 16'h0083);
    rd(8'h39, 16'h0093);
    rd(8'h3a, 16'h0101);
    wr(8'h39, 16'h0000);
    send(17'd3, 1'b1);
    wr(8'h39, 16'h0080);
    rd(8'h3a, 16'h0101);
    wr(8'h3a, 16'h1234);
    rd(8'h3a, 16'h0101);
    rd(8'h50, 16'h0000);
    give_verdict;
  end
endmodule // tb
